// file: bft_timing.sv
module bft_timing #(
  parameter int unsigned STEP_CYCLES = bft_pkg::STEP_CYCLES,
  parameter int unsigned STEP_W = bft_pkg::STEP_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire bft_pkg::bft_meas_t meas,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic redundantTrip,
  output logic breaker_failure_command,
  output logic irq
);
  // Timing in short: the measurement inputs are taken at every edge and
  // decide, per criterion, whether the delay counters run or clear.
  // One shared prescaler turns clock cycles into delay steps; each channel
  // counts steps up to its own setting and then raises its output flop.
  // A delay of N steps shows at the output about N * STEP_CYCLES + 1
  // cycles after the start condition is first seen.
  // The outputs stay up for as long as the release condition is absent and
  // drop in the cycle after it is seen. A pause of the start condition that
  // is not a release, which none of the three criteria can give,
  // freezes the counts where they are rather than losing them.
  // The register bus answers every access after exactly one wait cycle.

  // Prescaler width: one delay step in clock cycles must fit
  localparam int CW = $clog2(STEP_CYCLES + 1);
  // Channel numbers; both channels share one prescaler and one start
  localparam int CH_RT = 0;
  localparam int CH_BF = 1;
  localparam int N_CH = 2;
  // Status word bit positions
  localparam int STAT_RUN = 0;
  localparam int STAT_RT = 1;
  localparam int STAT_BF = 2;

  // Refuse settings that the prescaler or the 32-bit bus cannot serve
  initial begin
    if (STEP_CYCLES < 1 || STEP_W < 8 || STEP_W > 32) begin
      $error("bft_timing: unsupported parameters");
    end
  end

  // Register select, shared by the write path and the read path
  function automatic logic regHit(input logic [4:0] addr, input logic [4:0] offset);
    regHit = (addr == offset);
  endfunction

  // Settings written by software
  logic [1:0] mode_r;
  logic retripEn_r;
  logic [STEP_W-1:0] retripDly_r;
  logic [STEP_W-1:0] bfDly_r;
  logic [bft_pkg::IRQ_W-1:0] irqMask_r;
  // Bus handshake state
  logic ack_r;
  logic accWr;
  logic accRd;
  logic [31:0] rdMux;
  // Start and release of the delay counters
  logic currentUp;
  logic runCount;
  logic clearCount;
  logic startPrev_r;
  // Shared step prescaler
  logic [CW-1:0] tick_r;
  logic stepTick;
  // Per-channel delay state
  logic [STEP_W-1:0] chDly [N_CH];
  logic chEn [N_CH];
  logic [STEP_W-1:0] chCnt_r [N_CH];
  logic chFire_r [N_CH];
  logic chDue [N_CH];
  logic chRise [N_CH];
  // Interrupt state
  logic [bft_pkg::IRQ_W-1:0] irqStat_r;
  logic [bft_pkg::IRQ_W-1:0] irqEvt;
  logic [bft_pkg::IRQ_W-1:0] irqClr;
  logic [2:0] statusWord;

  // Start and release conditions for the selected criterion; the spare
  // code falls back to current only, so a stray write cannot mute protection
  always_comb begin
    currentUp = meas.phasePickup | meas.residualPickup;
    runCount = currentUp;
    clearCount = ~currentUp;
    case (bft_pkg::bft_mode_t'(mode_r))
      bft_pkg::BFT_CUR_AND_DO: begin
        // Pick-up alone clears the counts; only pick-up with the trip contact lets them run
        runCount = currentUp & meas.primaryTrip;
        clearCount = ~currentUp | ~meas.primaryTrip;
      end
      bft_pkg::BFT_CUR_OR_DO: begin
        // Either cause keeps the counts going, both must drop to clear
        runCount = currentUp | meas.primaryTrip;
        clearCount = ~currentUp & ~meas.primaryTrip;
      end
      default: begin
        // Current only: the trip contact is not looked at
        runCount = currentUp;
        clearCount = ~currentUp;
      end
    endcase
  end

  // Bus handshake: a request is seen with ack low and waitrequest drops for
  // one cycle. Read data are loaded at that first edge so that they stand at
  // the answer edge; a write lands at the answer edge, where the master
  // takes it as done, and never on a request the master is still holding.
  assign accRd = avs_read & ~ack_r;
  assign accWr = avs_write & ack_r;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
      avs_waitrequest <= ~((avs_read | avs_write) & ~ack_r);
    end
  end

  // Criterion select; taken at once, even in the middle of a run
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_r <= bft_pkg::MODE_RESET;
    end else if (accWr && regHit(avs_address, {1'b0, bft_pkg::REG_CTRL})) begin
      mode_r <= avs_writedata[bft_pkg::CTRL_MODE_LSB +: 2];
    end
  end

  // Retrip enable; on after reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      retripEn_r <= bft_pkg::RETRIP_EN_RESET;
    end else if (accWr && regHit(avs_address, {1'b0, bft_pkg::REG_CTRL})) begin
      retripEn_r <= avs_writedata[bft_pkg::CTRL_RETRIP_EN];
    end
  end

  // Retrip delay in steps
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      retripDly_r <= STEP_W'(bft_pkg::RETRIP_DEF_STEPS);
    end else if (accWr && regHit(avs_address, {1'b0, bft_pkg::REG_RETRIP_DLY})) begin
      retripDly_r <= avs_writedata[STEP_W-1:0];
    end
  end

  // Breaker failure delay in steps; software keeps it above the retrip delay
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bfDly_r <= STEP_W'(bft_pkg::BF_DEF_STEPS);
    end else if (accWr && regHit(avs_address, {1'b0, bft_pkg::REG_BF_DLY})) begin
      bfDly_r <= avs_writedata[STEP_W-1:0];
    end
  end

  // Interrupt mask; all events masked after reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irqMask_r <= '0;
    end else if (accWr && regHit(avs_address, bft_pkg::REG_IRQ_MASK)) begin
      irqMask_r <= avs_writedata[bft_pkg::IRQ_W-1:0];
    end
  end

  // Live status: running, retrip and failure outputs
  always_comb begin
    statusWord = '0;
    statusWord[STAT_RUN] = runCount;
    statusWord[STAT_RT] = redundantTrip;
    statusWord[STAT_BF] = breaker_failure_command;
  end

  // Read selection; unmapped offsets read zero rather than stale data
  always_comb begin
    rdMux = 32'h0000_0000;
    if (regHit(avs_address, {1'b0, bft_pkg::REG_CTRL})) begin
      rdMux = 32'({retripEn_r, mode_r});
    end else if (regHit(avs_address, {1'b0, bft_pkg::REG_RETRIP_DLY})) begin
      rdMux = 32'(retripDly_r);
    end else if (regHit(avs_address, {1'b0, bft_pkg::REG_BF_DLY})) begin
      rdMux = 32'(bfDly_r);
    end else if (regHit(avs_address, {1'b0, bft_pkg::REG_STATUS})) begin
      rdMux = 32'(statusWord);
    end else if (regHit(avs_address, bft_pkg::REG_IRQ_STAT)) begin
      rdMux = 32'(irqStat_r);
    end else if (regHit(avs_address, bft_pkg::REG_IRQ_MASK)) begin
      rdMux = 32'(irqMask_r);
    end
  end

  // Read data are loaded once per access and then held for the master
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (accRd) begin
      avs_readdata <= rdMux;
    end
  end

  // Step prescaler; it restarts from zero on every new start, so a pause
  // never carries part of a step into the next run
  assign stepTick = (tick_r == CW'(STEP_CYCLES - 1));
  always_ff @(posedge clk) begin
    if (sys_rst || clearCount || !runCount || stepTick) begin
      tick_r <= '0;
    end else begin
      tick_r <= tick_r + 1'b1;
    end
  end

  // Channel settings: the retrip channel obeys its enable, the failure
  // channel always runs, which also serves the trip-and-failure-only use
  assign chDly[CH_RT] = retripDly_r;
  assign chDly[CH_BF] = bfDly_r;
  assign chEn[CH_RT] = retripEn_r;
  assign chEn[CH_BF] = 1'b1;

  // One delay counter per channel. The output is set once the count has
  // reached the setting while the start condition still holds, and it is
  // dropped in the cycle after the release condition is seen.
  for (genvar ch = 0; ch < N_CH; ch++) begin : g_chan
    // Delay reached; also feeds the rise event for the interrupt
    assign chDue[ch] = (chCnt_r[ch] >= chDly[ch]);
    assign chRise[ch] = chDue[ch] & runCount & ~clearCount & chEn[ch] & ~chFire_r[ch];

    // Counter and output flop; a disabled channel is held cleared
    always_ff @(posedge clk) begin
      if (sys_rst || clearCount || !chEn[ch]) begin
        chCnt_r[ch] <= '0;
        chFire_r[ch] <= 1'b0;
      end else if (runCount) begin
        if (chDue[ch]) begin
          chFire_r[ch] <= 1'b1;
        end else if (stepTick) begin
          chCnt_r[ch] <= chCnt_r[ch] + 1'b1;
        end
      end
    end
  end

  // Outputs come straight from the channel flops
  assign redundantTrip = chFire_r[CH_RT];
  assign breaker_failure_command = chFire_r[CH_BF];

  // Start history for the start event; low after reset like an idle input
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      startPrev_r <= 1'b0;
    end else begin
      startPrev_r <= runCount;
    end
  end

  // Interrupt events: a new start and the rise of each output
  always_comb begin
    irqEvt = '0;
    irqEvt[bft_pkg::IRQ_START] = runCount & ~startPrev_r;
    irqEvt[bft_pkg::IRQ_RETRIP] = chRise[CH_RT];
    irqEvt[bft_pkg::IRQ_BF] = chRise[CH_BF];
  end

  // Write-one-to-clear mask for the status bits
  assign irqClr = (accWr && regHit(avs_address, bft_pkg::REG_IRQ_STAT))
                  ? avs_writedata[bft_pkg::IRQ_W-1:0] : '0;

  // Sticky status; a set beats a clear in the same cycle so no event is lost
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irqStat_r <= '0;
    end else begin
      irqStat_r <= (irqStat_r & ~irqClr) | irqEvt;
    end
  end

  // Level interrupt, one cycle behind the status so it leaves a flop
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStat_r & irqMask_r);
    end
  end
endmodule

// file: bft_pkg.sv
package bft_pkg;
  // Clock rate and time units
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned US_PER_S = 1_000_000;
  localparam int unsigned CLK_PER_US = CLK_HZ / US_PER_S;
  // Delay step and defaults in microseconds
  localparam int unsigned DLY_STEP_US = 5_000;
  localparam int unsigned RETRIP_DEF_US = 100_000;
  localparam int unsigned BF_DEF_US = 200_000;
  localparam int unsigned RETRIP_DEF_STEPS = RETRIP_DEF_US / DLY_STEP_US;
  localparam int unsigned BF_DEF_STEPS = BF_DEF_US / DLY_STEP_US;
  localparam int unsigned STEP_CYCLES = DLY_STEP_US * CLK_PER_US;
  localparam int unsigned STEP_W = 16;

  // Register byte offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_RETRIP_DLY = 4'h4;
  localparam logic [3:0] REG_BF_DLY = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hC;
  // Wide decode space for status extras
  localparam logic [4:0] REG_IRQ_STAT = 5'h10;
  localparam logic [4:0] REG_IRQ_MASK = 5'h14;

  // Control field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_RETRIP_EN = 2;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic RETRIP_EN_RESET = 1'b1;

  // Criterion encoding
  typedef enum logic [1:0] {
    BFT_CUR_ONLY = 2'h0,
    BFT_CUR_AND_DO = 2'h1,
    BFT_CUR_OR_DO = 2'h2
  } bft_mode_t;

  // Interrupt bits: start, retrip, breaker failure
  localparam int IRQ_W = 3;
  localparam int IRQ_START = 0;
  localparam int IRQ_RETRIP = 1;
  localparam int IRQ_BF = 2;

  // Protection inputs carried together
  typedef struct packed {
    logic phasePickup;
    logic residualPickup;
    logic primaryTrip;
  } bft_meas_t;
endpackage

// file: bft_checker.sv
module bft_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire bft_pkg::bft_meas_t meas,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic redundantTrip,
  input wire logic breaker_failure_command,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic cur;
  logic cause;
  // Every criterion needs current or trip to start, and all clear once both are gone
  assign cur = meas.phasePickup | meas.residualPickup;
  assign cause = cur | meas.primaryTrip;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_bf_idle_clear: assert property ((!cause)[*4] |-> !breaker_failure_command)
    else $error("failure output held while idle");
  a_rt_idle_clear: assert property ((!cause)[*4] |-> !redundantTrip)
    else $error("retrip output held while idle");
  a_bf_rise_cause: assert property ($rose(breaker_failure_command) |-> $past(cause, 2))
    else $error("failure output rose without pick-up");
  a_rt_rise_cause: assert property ($rose(redundantTrip) |-> $past(cause, 2))
    else $error("retrip output rose without pick-up");
  a_bf_fall_clear: assert property ($fell(breaker_failure_command) |-> $past(!cur) || $past(!meas.primaryTrip))
    else $error("failure output fell without clear");
  a_reset_quiet: assert property ($fell(sys_rst) |-> !redundantTrip && !breaker_failure_command && !irq)
    else $error("outputs active after reset");
  a_wait_stands: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest)
    else $error("bus access not answered");
  // Main scenarios
  c_retrip: cover property ($rose(redundantTrip));
  c_failure: cover property ($rose(breaker_failure_command));
  c_irq_clear: cover property ($fell(irq));
endmodule

// file: bft_breaker_model.sv
module bft_breaker_model (
  input wire logic clk,
  input wire logic phaseFault,
  input wire logic resFault,
  input wire logic tripCmd,
  output bft_pkg::bft_meas_t meas
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pick-ups and trip contact arrive a cycle late, as from a real measurement chain
  initial meas = 3'h0;
  always @(posedge clk) meas <= '{phaseFault, resFault, tripCmd};
endmodule

// file: bft_timing_tb.sv
module bft_timing_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, ph = 1'b0, res = 1'b0, tr = 1'b0;
  logic avs_waitrequest, rt, bf, irq;
  logic [4:0] avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  bft_pkg::bft_meas_t meas;
  int n_errors = 0, n_compared = 0;
  // Clock and the far side
  always #2 clk = ~clk;
  bft_breaker_model u_brk (.clk(clk), .phaseFault(ph), .resFault(res), .tripCmd(tr), .meas(meas));
  bft_timing #(.STEP_CYCLES(4)) u_dut (.clk(clk), .sys_rst(sys_rst), .meas(meas), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .redundantTrip(rt), .breaker_failure_command(bf), .irq(irq));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask
  // Request held until waitrequest is sampled low; the watchdog bounds the wait
  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_write <= w;
    avs_read <= ~w;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rchk(input logic [4:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic fault(input logic p, input logic r, input logic t);
    @(posedge clk);
    ph <= p;
    res <= r;
    tr <= t;
  endtask
  // Outputs after n cycles; delays are 2 and 4 steps of 4 cycles
  task automatic co(input int n, input logic [1:0] e);
    repeat (n) @(posedge clk);
    chk({30'h0, rt, bf}, {30'h0, e});
  endtask
  task automatic t_regs();
    rchk(5'h00, 32'h4);
    rchk(5'h04, 32'h14);
    rchk(5'h08, 32'h28);
    rchk(5'h18, 32'h0);
    acc(1'b1, 5'h04, 32'h2);
    acc(1'b1, 5'h08, 32'h4);
    acc(1'b1, 5'h14, 32'h7);
  endtask
  task automatic t_cur();
    fault(1'b0, 1'b1, 1'b0);
    co(6, 2'h0);
    co(8, 2'h2);
    co(12, 2'h3);
    rchk(5'h0C, 32'h7);
    chk({31'h0, irq}, 32'h1);
    fault(1'b0, 1'b0, 1'b1);
    co(4, 2'h0);
    fault(1'b0, 1'b0, 1'b0);
    rchk(5'h10, 32'h7);
    acc(1'b1, 5'h10, 32'h7);
    rchk(5'h10, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask
  task automatic t_and();
    acc(1'b1, 5'h00, 32'h5);
    fault(1'b1, 1'b0, 1'b0);
    co(26, 2'h0);
    fault(1'b1, 1'b0, 1'b1);
    co(14, 2'h2);
    co(12, 2'h3);
    fault(1'b1, 1'b0, 1'b0);
    co(4, 2'h0);
    fault(1'b0, 1'b0, 1'b0);
  endtask
  task automatic t_or();
    acc(1'b1, 5'h00, 32'h6);
    fault(1'b0, 1'b0, 1'b1);
    co(26, 2'h3);
    fault(1'b1, 1'b0, 1'b0);
    co(4, 2'h3);
    fault(1'b0, 1'b0, 1'b0);
    co(4, 2'h0);
  endtask
  // Retrip off with interrupts masked: only the failure path may act
  task automatic t_noretrip();
    acc(1'b1, 5'h14, 32'h0);
    acc(1'b1, 5'h00, 32'h3);
    fault(1'b1, 1'b0, 1'b0);
    co(26, 2'h1);
    chk({31'h0, irq}, 32'h0);
    fault(1'b0, 1'b0, 1'b0);
    co(4, 2'h0);
  endtask
  task automatic final_report();
    if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Main sequence after 16 reset cycles
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_cur();
    t_and();
    t_or();
    t_noretrip();
    final_report();
  end
  // Watchdog: the run needs well under 1000 cycles
  initial begin
    #20000;
    n_errors++;
    final_report();
  end
endmodule
bind bft_timing bft_checker u_chk (.clk(clk), .sys_rst(sys_rst), .meas(meas), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .redundantTrip(redundantTrip),
  .breaker_failure_command(breaker_failure_command), .irq(irq));
